//--- rtl/dscs_defines.svh
// offsets, field positions, reset values and counts of the double-speed clock select
`ifndef DSCS_DEFINES_SVH
`define DSCS_DEFINES_SVH

`define DSCS_OFF_CLOCK_CONTROL_REG      8'h00
`define DSCS_OFF_STATUS     8'h04
`define DSCS_CK_DS_BIT      0
`define DSCS_CK_PER_LSB     1
`define DSCS_CK_PER_MSB     6
`define DSCS_CLOCK_CONTROL_REG_RST      7'h00
`define DSCS_NUM_PERIPH     6
`define DSCS_BOOT_BIT       7
`define DSCS_ST_ACTIVE_BIT  0
`define DSCS_ST_BOOT_BIT    1
`define DSCS_STD_CLKS       12
`define DSCS_DS_CLKS        6
`define DSCS_TICKS_PER_MC   3'h6
`define DSCS_LAST_PHASE     3'h5

`endif

//--- rtl/dscs_pkg.sv
// types shared by the double-speed clock select files
`default_nettype none
package dscs_pkg;
    typedef struct packed {
        logic [5:0] periphDiv;
        logic       doubleSpeed;
    } dscs_clock_control_reg_s;

    typedef struct packed {
        logic       cpu;
        logic [5:0] periph;
        logic       machineCycle;
    } dscs_ticks_s;

    typedef enum logic [1:0] {
        BOOT_WAIT = 2'b01,
        BOOT_RUN  = 2'b10
    } dscs_boot_e;
endpackage : dscs_pkg
`default_nettype wire

//--- rtl/dscs_mode_switch.sv
// crystal halving stage and glitch-free validation of the requested speed mode
`default_nettype none
module dscs_mode_switch (
    // clock and reset
    input  wire logic clock,
    input  wire logic rstn,
    // request from the control register
    input  wire logic requestDouble,
    // halved clock phase and validated mode
    output logic      halfClk,
    output logic      doubleActive
);
    logic halfClk_reg;
    logic doubleActive_reg;

    ////////////////////////////////////////////////////////////////////////////
    // divide by two of the crystal input
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            halfClk_reg <= 1'b0;
        end else begin
            halfClk_reg <= ~halfClk_reg;
        end
    end

    // mode only moves when the halved clock rises, so a half period is never cut short
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            doubleActive_reg <= 1'b0;
        end else if (!halfClk_reg) begin
            doubleActive_reg <= requestDouble;
        end
    end

    assign halfClk      = halfClk_reg;
    assign doubleActive = doubleActive_reg;

    ////////////////////////////////////////////////////////////////////////////
    AST_MODE_ON_HALF_RISE: assert property (@(posedge clock) disable iff (!rstn)
        $changed(doubleActive_reg) |-> halfClk_reg && !$past(halfClk_reg))
        else $error("mode changed off a halved clock rising edge");
endmodule : dscs_mode_switch
`default_nettype wire

//--- rtl/dscs_clock_select.sv
// double-speed clock select: control register, boot mode, cpu and peripheral clock enables
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`include "dscs_defines.svh"
`default_nettype none
module dscs_clock_select (
    // clock and reset
    input  wire logic                clock,
    input  wire logic                rstn,
    // wishbone classic slave
    input  wire logic                cyc_i,
    input  wire logic                stb_i,
    input  wire logic                we_i,
    input  wire logic [7:0]          adr_i,
    input  wire logic [7:0]          dat_i,
    input  wire logic [0:0]          sel_i,
    output logic      [7:0]          dat_o,
    output logic                     ack_o,
    // nonvolatile security byte
    input  wire logic [7:0]          securityByte,
    // clock enables and mode
    output var dscs_pkg::dscs_ticks_s tickOut,
    output logic                     doubleActive
);
    dscs_pkg::dscs_clock_control_reg_s clock_control_reg_reg;
    dscs_pkg::dscs_boot_e  bootState_reg;
    dscs_pkg::dscs_ticks_s ticks_reg;
    dscs_pkg::dscs_ticks_s ticks_next;
    logic                  bootDouble_reg;
    logic                  ack_reg;
    logic [7:0]            dat_reg;
    logic [2:0]            phase_reg;
    logic                  halfClk;
    logic                  wbReq;
    logic                  wbWrite;
    logic [5:0]            periphFast;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode: a write lands on the edge where the master sees ack
    assign wbReq   = cyc_i && stb_i && !ack_reg;
    assign wbWrite = cyc_i && stb_i && we_i && ack_reg && sel_i[0] && (adr_i == `DSCS_OFF_CLOCK_CONTROL_REG);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wbReq;
        end
    end

    // unmapped addresses answer with zero rather than stalling the bus
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dat_reg <= 8'h00;
        end else if (wbReq) begin
            case (adr_i)
                `DSCS_OFF_CLOCK_CONTROL_REG:  dat_reg <= {1'b0, clock_control_reg_reg};
                `DSCS_OFF_STATUS: dat_reg <= {6'h00, bootDouble_reg, doubleActive};
                default:          dat_reg <= 8'h00;
            endcase
        end
    end

    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

    ////////////////////////////////////////////////////////////////////////////
    // boot sequence: security byte is sampled once, on the first edge after reset release
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bootState_reg <= dscs_pkg::BOOT_WAIT;
        end else begin
            case (bootState_reg)
                dscs_pkg::BOOT_WAIT: bootState_reg <= dscs_pkg::BOOT_RUN;
                dscs_pkg::BOOT_RUN:  bootState_reg <= dscs_pkg::BOOT_RUN;
                default:             bootState_reg <= dscs_pkg::BOOT_RUN;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bootDouble_reg <= 1'b0;
        end else if (bootState_reg == dscs_pkg::BOOT_WAIT) begin
            bootDouble_reg <= ~securityByte[`DSCS_BOOT_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            clock_control_reg_reg <= `DSCS_CLOCK_CONTROL_REG_RST;
        end else if (bootState_reg == dscs_pkg::BOOT_WAIT) begin
            clock_control_reg_reg.doubleSpeed <= ~securityByte[`DSCS_BOOT_BIT];
        end else if (wbWrite) begin
            clock_control_reg_reg.doubleSpeed <= dat_i[`DSCS_CK_DS_BIT];
            clock_control_reg_reg.periphDiv   <= dat_i[`DSCS_CK_PER_MSB:`DSCS_CK_PER_LSB];
        end
    end

    dscs_mode_switch u_mode (
        .clock         (clock),
        .rstn          (rstn),
        .requestDouble (clock_control_reg_reg.doubleSpeed),
        .halfClk       (halfClk),
        .doubleActive  (doubleActive)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock enables: the halved stage gives one tick in two crystal periods
    always_comb begin
        ticks_next              = ticks_reg;
        ticks_next.cpu          = doubleActive || halfClk;
        ticks_next.machineCycle = ticks_reg.cpu && (phase_reg == `DSCS_LAST_PHASE);
        ticks_next.periph       = periphFast;
    end

    // per-bit enables live in their own vector so the tick struct keeps a single driver
    generate
        for (genvar i = 0; i < `DSCS_NUM_PERIPH; i++) begin : g_periph
            // a set bit keeps the peripheral on the halved clock whatever the cpu does
            assign periphFast[i] = (doubleActive && !clock_control_reg_reg.periphDiv[i]) || halfClk;

            AST_PERIPH_HELD: assert property (@(posedge clock) disable iff (!rstn)
                clock_control_reg_reg.periphDiv[i] && !halfClk |=> !ticks_reg.periph[i])
                else $error("held peripheral ticked at the crystal rate");
            AST_PERIPH_FAST: assert property (@(posedge clock) disable iff (!rstn)
                doubleActive && !clock_control_reg_reg.periphDiv[i] |=> ticks_reg.periph[i])
                else $error("released peripheral missed a double speed tick");
        end
    endgenerate

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ticks_reg <= '0;
        end else begin
            ticks_reg <= ticks_next;
        end
    end

    // six cpu ticks make a machine cycle, so the crystal count follows the mode
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            phase_reg <= 3'h0;
        end else if (ticks_reg.cpu) begin
            phase_reg <= (phase_reg == `DSCS_LAST_PHASE) ? 3'h0 : phase_reg + 3'h1;
        end
    end

    assign tickOut = ticks_reg;

    ////////////////////////////////////////////////////////////////////////////
    // helper: crystal periods between machine cycles, flagged when the mode moved inside
    logic [4:0] gap_reg;
    logic       mixed_reg;
    logic       prevActive_reg;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            gap_reg        <= 5'h00;
            mixed_reg      <= 1'b1;
            prevActive_reg <= 1'b0;
        end else begin
            prevActive_reg <= doubleActive;
            gap_reg        <= ticks_reg.machineCycle ? 5'h01 : gap_reg + 5'h01;
            mixed_reg      <= (ticks_reg.machineCycle ? 1'b0 : mixed_reg) || (doubleActive != prevActive_reg);
        end
    end

    // the mode of a finished interval is the one seen a cycle before its pulse, as the ticks lag by one
    AST_STD_CADENCE: assert property (@(posedge clock) disable iff (!rstn)
        ticks_reg.machineCycle && !mixed_reg && !prevActive_reg && gap_reg != 5'h00
        |-> gap_reg == 5'(`DSCS_STD_CLKS))
        else $error("standard machine cycle not twelve clocks");
    AST_DS_CADENCE: assert property (@(posedge clock) disable iff (!rstn)
        ticks_reg.machineCycle && !mixed_reg && prevActive_reg && gap_reg != 5'h00
        |-> gap_reg == 5'(`DSCS_DS_CLKS))
        else $error("double speed machine cycle not six clocks");
    AST_RESET_STD: assert property (@(posedge clock) disable iff (!rstn)
        bootState_reg == dscs_pkg::BOOT_WAIT |-> !clock_control_reg_reg.doubleSpeed && !doubleActive)
        else $error("select bit not in standard mode after reset");
    AST_STD_DIVIDED: assert property (@(posedge clock) disable iff (!rstn)
        !doubleActive ##1 !doubleActive |=> ticks_reg.cpu != $past(ticks_reg.cpu))
        else $error("standard mode cpu tick not halved");
    AST_DS_UNDIVIDED: assert property (@(posedge clock) disable iff (!rstn)
        doubleActive |=> ticks_reg.cpu)
        else $error("double mode cpu tick not at crystal rate");
    AST_BOOT_DOUBLE: assert property (@(posedge clock) disable iff (!rstn)
        bootState_reg == dscs_pkg::BOOT_WAIT && !securityByte[`DSCS_BOOT_BIT]
        |=> clock_control_reg_reg.doubleSpeed ##[1:2] doubleActive)
        else $error("cleared boot bit did not start double speed");
    AST_BOOT_STD: assert property (@(posedge clock) disable iff (!rstn)
        bootState_reg == dscs_pkg::BOOT_WAIT && securityByte[`DSCS_BOOT_BIT] |=> !clock_control_reg_reg.doubleSpeed)
        else $error("set boot bit did not start standard mode");
    AST_CPU_ONLY: assert property (@(posedge clock) disable iff (!rstn)
        doubleActive && (&clock_control_reg_reg.periphDiv) && !halfClk |=> ticks_reg.cpu && ticks_reg.periph == 6'h00)
        else $error("peripherals sped up with all bits set");
    AST_MODE_FOLLOWS: assert property (@(posedge clock) disable iff (!rstn)
        $changed(clock_control_reg_reg.doubleSpeed) |-> ##[1:2] (doubleActive == clock_control_reg_reg.doubleSpeed))
        else $error("validated mode did not follow the select bit");
    AST_WB_ACK: assert property (@(posedge clock) disable iff (!rstn)
        cyc_i && stb_i && !ack_reg |=> ack_reg ##1 !ack_reg)
        else $error("bus ack not a single cycle after request");

    COV_BOOT_DOUBLE: cover property (@(posedge clock) disable iff (!rstn)
        bootState_reg == dscs_pkg::BOOT_RUN && bootDouble_reg && doubleActive);
    COV_TO_DOUBLE: cover property (@(posedge clock) disable iff (!rstn) $rose(doubleActive));
    COV_TO_STD: cover property (@(posedge clock) disable iff (!rstn) $fell(doubleActive));
    COV_HELD_PERIPH: cover property (@(posedge clock) disable iff (!rstn)
        doubleActive && clock_control_reg_reg.periphDiv[0]);
    COV_DS_CYCLE: cover property (@(posedge clock) disable iff (!rstn) ticks_reg.machineCycle && doubleActive);
endmodule : dscs_clock_select
`default_nettype wire

//--- tb/dscs_testbench.sv
// self-checking bench for the double-speed clock select: bus tasks and tick-rate scenarios
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////////////////////////////////////////////
    logic                  clock = 1'b0;
    logic                  rstn = 1'b0;
    logic                  cyc = 1'b0;
    logic                  stb = 1'b0;
    logic                  we = 1'b0;
    logic [7:0]            adr = 8'h00;
    logic [7:0]            wdat = 8'h00;
    logic [0:0]            sel = 1'b1;
    logic [7:0]            secByte = 8'h80;
    logic [7:0]            rdat;
    logic [7:0]            datO;
    logic                  ackO;
    logic                  dblAct;
    dscs_pkg::dscs_ticks_s ticks;
    int                    err_total = 0;
    int                    comparisons = 0;
    int                    cycles = 0;

    dscs_clock_select dut_u (.clock(clock), .rstn(rstn), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .dat_i(wdat), .sel_i(sel), .dat_o(datO), .ack_o(ackO), .securityByte(secByte), .tickOut(ticks),
        .doubleActive(dblAct));

    always #20 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // whole run is well under a thousand cycles; the ceiling leaves wide margin
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : check
    ////////////////////////////////////////////////////////////////////////////////
    // ack and read data are taken at the rising edge that sees ack, and only then is the request dropped
    task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [0:0] s,
                            output logic [7:0] q);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do @(posedge clock); while (ackO !== 1'b1);
        q = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb_cycle

    task automatic wb_write(input logic [7:0] a, input logic [7:0] d);
        wb_cycle(1'b1, a, d, 1'b1, rdat);
    endtask : wb_write

    task automatic wb_read(input logic [7:0] a, input logic [7:0] exp, input string msg);
        logic [7:0] q;
        wb_cycle(1'b0, a, 8'h00, 1'b1, q);
        check(q, exp, msg);
    endtask : wb_read

    task automatic do_reset(input logic [7:0] sec);
        @(posedge clock);
        rstn <= 1'b0;
        secByte <= sec;
        repeat (2) @(negedge clock);
        check({6'h00, ticks.cpu, dblAct}, 8'h00, "outputs in reset");
        repeat (7) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
    endtask : do_reset

    // counts cycles from the ack edge until the validated mode matches; halved-clock phase gives 2 or 3
    task automatic mode_wait(input logic target);
        int k;
        k = 0;
        do begin
            @(negedge clock);
            k++;
        end while (dblAct !== target && k < 8);
        check(8'(k >= 2 && k <= 3), 8'h01, "mode validation delay");
    endtask : mode_wait

    // 24 cycles of ticks; a gap between machine-cycle pulses is checked as well as the counts
    task automatic measure(input logic dbl, input logic [5:0] keep);
        int cpuCnt;
        int mcCnt;
        int last;
        int per [6];
        cpuCnt = 0;
        mcCnt = 0;
        last = -1;
        per = '{default: 0};
        repeat (4) @(negedge clock);
        for (int t = 0; t < 24; t++) begin
            @(negedge clock);
            if (ticks.cpu === 1'b1) cpuCnt++;
            for (int i = 0; i < 6; i++) if (ticks.periph[i] === 1'b1) per[i]++;
            if (ticks.machineCycle === 1'b1) begin
                mcCnt++;
                if (last >= 0) check(8'(t - last), dbl ? 8'h06 : 8'h0c, "machine cycle length");
                last = t;
            end
        end
        check(8'(cpuCnt), dbl ? 8'h18 : 8'h0c, "cpu ticks");
        check(8'(mcCnt), dbl ? 8'h04 : 8'h02, "machine cycles");
        for (int i = 0; i < 6; i++) begin
            check(8'(per[i]), (dbl && !keep[i]) ? 8'h18 : 8'h0c, "periph ticks");
        end
    endtask : measure
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset(8'h80);
        wb_read(8'h00, 8'h00, "control after reset");
        wb_read(8'h04, 8'h00, "status after reset");
        measure(1'b0, 6'h00);
        wb_write(8'h00, 8'h01);
        mode_wait(1'b1);
        wb_read(8'h04, 8'h01, "status double");
        measure(1'b1, 6'h00);
        for (int i = 0; i < 6; i++) begin
            wb_write(8'h00, 8'h01 | (8'h02 << i));
            measure(1'b1, 6'h01 << i);
        end
        wb_write(8'h00, 8'hff);
        wb_read(8'h00, 8'h7f, "control all kept");
        measure(1'b1, 6'h3f);
        wb_cycle(1'b1, 8'h00, 8'h00, 1'b0, rdat);
        wb_read(8'h00, 8'h7f, "write with sel low");
        wb_write(8'h08, 8'h01);
        wb_read(8'h08, 8'h00, "unmapped address");
        wb_write(8'h00, 8'h00);
        mode_wait(1'b0);
        wb_write(8'h04, 8'hff);
        wb_read(8'h04, 8'h00, "status read only");
        measure(1'b0, 6'h00);
        // a second reset in mid-run with the boot bit clear
        do_reset(8'h00);
        wb_read(8'h00, 8'h01, "control after double boot");
        wb_read(8'h04, 8'h03, "status after double boot");
        measure(1'b1, 6'h00);
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
